/* File: shared/cap_bank_pkg.sv */
// constants for the capability configuration bank
package cap_bank_pkg;
	localparam logic [11:0] msg_interrupt_config_addr       = 12'h0e8;
	localparam logic [11:0] ext_msg_interrupt_config_addr   = 12'h0f0;
	localparam logic [11:0] ext_vector_table_location_addr  = 12'h0f4;
	localparam logic [11:0] pending_bit_array_location_addr = 12'h0f8;
	localparam logic [11:0] vendor_specific_config_addr     = 12'h110;
	localparam logic [11:0] separate_refclk_skip_config_addr = 12'h120;
	localparam logic [11:0] serial_number_config_addr       = 12'h130;
	localparam logic [11:0] serial_number_value_addr        = 12'h134;
	localparam logic [11:0] power_budgeting_config_addr     = 12'h150;
	localparam logic [11:0] dynamic_power_config_addr       = 12'h158;
	localparam logic [11:0] dynamic_power_latency_select_addr = 12'h15c;
	localparam logic [11:0] dynamic_power_share_array_addr  = 12'h160;
	localparam logic [11:0] latency_tolerance_config_addr   = 12'h180;
	localparam logic [11:0] link_sleep_substate_config_addr = 12'h188;
	// writable-bit masks
	localparam logic [31:0] msg_interrupt_mask   = 32'h0000_0073;
	localparam logic [31:0] ext_msg_mask         = 32'h07ff_0001;
	localparam logic [31:0] location_mask        = 32'hffff_ffff;
	localparam logic [31:0] vendor_mask          = 32'hffff_0001;
	localparam logic [31:0] skip_mask            = 32'h0000_ff01;
	localparam logic [31:0] enable_only_mask     = 32'h0000_0001;
	localparam logic [31:0] budget_mask          = 32'h0000_0003;
	localparam logic [31:0] dynamic_mask         = 32'hffff_33f9;
	localparam logic [31:0] link_sleep_mask      = 32'hffff_fbf9;
	// reset values
	localparam logic [31:0] msg_interrupt_reset  = 32'h0000_0052;
	localparam logic [31:0] ext_msg_reset        = 32'h001f_0000;
	localparam logic [31:0] table_location_reset = 32'h0000_6000;
	localparam logic [31:0] pending_location_reset = 32'h0000_7000;
	localparam logic [31:0] vendor_reset         = 32'h0001_0001;
	localparam logic [31:0] link_sleep_reset     = 32'h0000_00f8;
	// field positions
	localparam int vector_count_lsb = 4;
	localparam int vec_mask_bit     = 1;
	localparam int hide_bit         = 0;
	localparam int enable_bit       = 0;
	localparam int table_size_lsb   = 16;
	localparam int offset_lsb       = 3;
	localparam int vendor_id_lsb    = 16;
	localparam int skip_gen_lsb     = 12;
	localparam int skip_rx_lsb      = 8;
	localparam int sys_alloc_bit    = 1;
	localparam int latency_one_lsb  = 24;
	localparam int latency_zero_lsb = 16;
	localparam int alloc_scale_lsb  = 12;
	localparam int latency_unit_lsb = 8;
	localparam int substate_max_lsb = 3;
	localparam int default_settle_lsb = 24;
	localparam int own_settle_lsb   = 16;
	localparam int power_on_value_lsb = 11;
	localparam int power_on_scale_lsb = 8;
	localparam int pm_first_bit     = 7;
	localparam int pm_second_bit    = 6;
	localparam int active_first_bit = 5;
	localparam int active_second_bit = 4;
	localparam int low_power_adv_bit = 3;
	localparam int share_words      = 8;
	localparam logic [7:0] bar_base_addr = 8'h10;
	localparam logic [2:0] last_bar_code = 3'h5;
	// latency unit in ms, scales in hundredths, power-on scale in us
	localparam logic [6:0] unit_1_ms = 7'h01;
	localparam logic [6:0] unit_10_ms = 7'h0a;
	localparam logic [6:0] unit_100_ms = 7'h64;
	localparam logic [10:0] scale_10x = 11'h3e8;
	localparam logic [10:0] scale_1x = 11'h064;
	localparam logic [10:0] scale_tenth = 11'h00a;
	localparam logic [10:0] scale_hundredth = 11'h001;
	localparam logic [6:0] on_2_us = 7'h02;
	localparam logic [6:0] on_10_us = 7'h0a;
	localparam logic [6:0] on_100_us = 7'h64;
endpackage : cap_bank_pkg

/* File: src/pcie_capability_config_bank.sv */
// apb register bank for advertised pcie capabilities
`timescale 1ns/1ps
`default_nettype none
module pcie_capability_config_bank
	import cap_bank_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	output var  logic        msi_present,
	output var  logic [5:0]  msi_vector_count,
	output var  logic        msi_vector_mask_adv,
	output var  logic        msix_present,
	output var  logic [11:0] msix_vector_count,
	output var  logic [31:0] msix_table_byte_offset,
	output var  logic [7:0]  msix_table_bar_addr,
	output var  logic        msix_table_bar_valid,
	output var  logic [31:0] msix_pending_byte_offset,
	output var  logic [7:0]  msix_pending_bar_addr,
	output var  logic        msix_pending_bar_valid,
	output var  logic        vendor_present,
	output var  logic [15:0] vendor_cap_id,
	output var  logic        skip_present,
	output var  logic [3:0]  skip_gen_speeds,
	output var  logic [3:0]  skip_rx_speeds,
	output var  logic        serial_present,
	output var  logic [63:0] serial_number,
	output var  logic        budget_present,
	output var  logic        budget_system_allocated,
	output var  logic        dynamic_present,
	output var  logic [5:0]  substate_count,
	output var  logic [6:0]  latency_unit_ms,
	output var  logic        latency_unit_reserved,
	output var  logic [10:0] alloc_scale_hundredths,
	output var  logic [31:0] latency_select,
	output var  logic [7:0]  latency_value_zero,
	output var  logic [7:0]  latency_value_one,
	output var  logic [255:0] share_array,
	output var  logic        tolerance_present,
	output var  logic        substates_present,
	output var  logic [11:0] power_on_time_us,
	output var  logic        power_on_scale_reserved,
	output var  logic [7:0]  default_common_mode_settle_us,
	output var  logic [7:0]  own_common_mode_settle_us,
	output var  logic [4:0]  substate_adv
);
	import cap_bank_pkg::*;

	logic [31:0] msg_interrupt_reg;
	logic [31:0] ext_msg_reg;
	logic [31:0] table_location_reg;
	logic [31:0] pending_location_reg;
	logic [31:0] vendor_reg;
	logic [31:0] skip_reg;
	logic [31:0] serial_config_reg;
	logic [31:0] serial_low_reg;
	logic [31:0] serial_high_reg;
	logic [31:0] budget_reg;
	logic [31:0] dynamic_reg;
	logic [31:0] latency_select_reg;
	logic [31:0] share_reg [share_words];
	logic [31:0] tolerance_reg;
	logic [31:0] link_sleep_reg;
	logic [31:0] strobe_mask;
	logic        wr_en;
	logic        mapped;
	logic [31:0] next_rdata;

	assign wr_en = psel && penable && pwrite && pready;

	always_comb begin
		strobe_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
	end

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wmask);
		merge = (old & ~(wmask & strobe_mask)) | (pwdata & wmask & strobe_mask);
	endfunction : merge

	// one-wait-state slave: pready high in the second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= psel && penable && !pready;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			msg_interrupt_reg <= msg_interrupt_reset;
			ext_msg_reg <= ext_msg_reset;
			table_location_reg <= table_location_reset;
			pending_location_reg <= pending_location_reset;
			vendor_reg <= vendor_reset;
			skip_reg <= 32'h0000_0000;
			serial_config_reg <= 32'h0000_0000;
			serial_low_reg <= 32'h0000_0000;
			serial_high_reg <= 32'h0000_0000;
			budget_reg <= 32'h0000_0000;
			dynamic_reg <= 32'h0000_0000;
			latency_select_reg <= 32'h0000_0000;
			tolerance_reg <= 32'h0000_0000;
			link_sleep_reg <= link_sleep_reset;
		end else if (wr_en) begin
			case (paddr)
				msg_interrupt_config_addr: msg_interrupt_reg <= merge(msg_interrupt_reg, msg_interrupt_mask);
				ext_msg_interrupt_config_addr: ext_msg_reg <= merge(ext_msg_reg, ext_msg_mask);
				ext_vector_table_location_addr: table_location_reg <= merge(table_location_reg, location_mask);
				pending_bit_array_location_addr: pending_location_reg <= merge(pending_location_reg, location_mask);
				vendor_specific_config_addr: vendor_reg <= merge(vendor_reg, vendor_mask);
				separate_refclk_skip_config_addr: skip_reg <= merge(skip_reg, skip_mask);
				serial_number_config_addr: serial_config_reg <= merge(serial_config_reg, enable_only_mask);
				serial_number_value_addr: serial_low_reg <= merge(serial_low_reg, location_mask);
				serial_number_value_addr + 12'h004: serial_high_reg <= merge(serial_high_reg, location_mask);
				power_budgeting_config_addr: budget_reg <= merge(budget_reg, budget_mask);
				dynamic_power_config_addr: dynamic_reg <= merge(dynamic_reg, dynamic_mask);
				dynamic_power_latency_select_addr: latency_select_reg <= merge(latency_select_reg, location_mask);
				latency_tolerance_config_addr: tolerance_reg <= merge(tolerance_reg, enable_only_mask);
				link_sleep_substate_config_addr: link_sleep_reg <= merge(link_sleep_reg, link_sleep_mask);
				default: begin
				end
			endcase
		end
	end

	// allocation array, one word per group of four substates
	generate
		for (genvar w = 0; w < share_words; w++) begin : g_share
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					share_reg[w] <= 32'h0000_0000;
				end else if (wr_en && paddr == dynamic_power_share_array_addr + 12'(4 * w)) begin
					share_reg[w] <= merge(share_reg[w], location_mask);
				end
			end
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					share_array[w*32 +: 32] <= 32'h0000_0000;
				end else begin
					share_array[w*32 +: 32] <= share_reg[w];
				end
			end
		end
	endgenerate

	always_comb begin
		mapped = 1'b1;
		next_rdata = 32'h0000_0000;
		case (paddr)
			msg_interrupt_config_addr: next_rdata = msg_interrupt_reg;
			ext_msg_interrupt_config_addr: next_rdata = ext_msg_reg;
			ext_vector_table_location_addr: next_rdata = table_location_reg;
			pending_bit_array_location_addr: next_rdata = pending_location_reg;
			vendor_specific_config_addr: next_rdata = vendor_reg;
			separate_refclk_skip_config_addr: next_rdata = skip_reg;
			serial_number_config_addr: next_rdata = serial_config_reg;
			serial_number_value_addr: next_rdata = serial_low_reg;
			serial_number_value_addr + 12'h004: next_rdata = serial_high_reg;
			power_budgeting_config_addr: next_rdata = budget_reg;
			dynamic_power_config_addr: next_rdata = dynamic_reg;
			dynamic_power_latency_select_addr: next_rdata = latency_select_reg;
			latency_tolerance_config_addr: next_rdata = tolerance_reg;
			link_sleep_substate_config_addr: next_rdata = link_sleep_reg;
			default: begin
				if (paddr[11:5] == dynamic_power_share_array_addr[11:5] && paddr[1:0] == 2'b00) begin
					next_rdata = share_reg[paddr[4:2]];
				end else begin
					mapped = 1'b0;
				end
			end
		endcase
		if (paddr[1:0] != 2'b00) begin
			mapped = 1'b0;
			next_rdata = 32'h0000_0000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			prdata <= (psel && penable && !pwrite && !pready) ? next_rdata : 32'h0000_0000;
			pslverr <= psel && penable && !pready && !mapped;
		end
	end

	// decoded advertisement outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			msi_present <= 1'b0;
			msi_vector_count <= 6'h00;
			msi_vector_mask_adv <= 1'b0;
			msix_present <= 1'b0;
			msix_vector_count <= 12'h000;
			msix_table_byte_offset <= 32'h0000_0000;
			msix_table_bar_addr <= 8'h00;
			msix_table_bar_valid <= 1'b0;
			msix_pending_byte_offset <= 32'h0000_0000;
			msix_pending_bar_addr <= 8'h00;
			msix_pending_bar_valid <= 1'b0;
		end else begin
			msi_present <= !msg_interrupt_reg[hide_bit];
			msi_vector_count <= (msg_interrupt_reg[vector_count_lsb +: 3] <= 3'h5)
				? 6'(6'h01 << msg_interrupt_reg[vector_count_lsb +: 3]) : 6'h00;
			msi_vector_mask_adv <= msg_interrupt_reg[vec_mask_bit];
			msix_present <= !ext_msg_reg[hide_bit];
			msix_vector_count <= {1'b0, ext_msg_reg[table_size_lsb +: 11]} + 12'h001;
			msix_table_byte_offset <= {table_location_reg[31:offset_lsb], 3'b000};
			msix_table_bar_valid <= table_location_reg[2:0] <= last_bar_code;
			msix_table_bar_addr <= (table_location_reg[2:0] <= last_bar_code)
				? bar_base_addr + {3'h0, table_location_reg[2:0], 2'b00} : 8'h00;
			msix_pending_byte_offset <= {pending_location_reg[31:offset_lsb], 3'b000};
			msix_pending_bar_valid <= pending_location_reg[2:0] <= last_bar_code;
			msix_pending_bar_addr <= (pending_location_reg[2:0] <= last_bar_code)
				? bar_base_addr + {3'h0, pending_location_reg[2:0], 2'b00} : 8'h00;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vendor_present <= 1'b0;
			vendor_cap_id <= 16'h0000;
			skip_present <= 1'b0;
			skip_gen_speeds <= 4'h0;
			skip_rx_speeds <= 4'h0;
			serial_present <= 1'b0;
			serial_number <= 64'h0;
			budget_present <= 1'b0;
			budget_system_allocated <= 1'b0;
		end else begin
			vendor_present <= vendor_reg[enable_bit];
			vendor_cap_id <= vendor_reg[vendor_id_lsb +: 16];
			skip_present <= skip_reg[enable_bit];
			skip_gen_speeds <= skip_reg[skip_gen_lsb +: 4];
			skip_rx_speeds <= skip_reg[skip_rx_lsb +: 4];
			serial_present <= serial_config_reg[enable_bit];
			serial_number <= {serial_high_reg, serial_low_reg};
			budget_present <= budget_reg[enable_bit];
			budget_system_allocated <= budget_reg[sys_alloc_bit];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dynamic_present <= 1'b0;
			substate_count <= 6'h00;
			latency_unit_ms <= 7'h00;
			latency_unit_reserved <= 1'b0;
			alloc_scale_hundredths <= 11'h000;
			latency_select <= 32'h0000_0000;
			latency_value_zero <= 8'h00;
			latency_value_one <= 8'h00;
		end else begin
			dynamic_present <= dynamic_reg[enable_bit];
			substate_count <= {1'b0, dynamic_reg[substate_max_lsb +: 5]} + 6'h01;
			case (dynamic_reg[latency_unit_lsb +: 2])
				2'h0: latency_unit_ms <= unit_1_ms;
				2'h1: latency_unit_ms <= unit_10_ms;
				2'h2: latency_unit_ms <= unit_100_ms;
				default: latency_unit_ms <= 7'h00;
			endcase
			latency_unit_reserved <= dynamic_reg[latency_unit_lsb +: 2] == 2'h3;
			case (dynamic_reg[alloc_scale_lsb +: 2])
				2'h0: alloc_scale_hundredths <= scale_10x;
				2'h1: alloc_scale_hundredths <= scale_1x;
				2'h2: alloc_scale_hundredths <= scale_tenth;
				default: alloc_scale_hundredths <= scale_hundredth;
			endcase
			latency_select <= latency_select_reg;
			latency_value_zero <= dynamic_reg[latency_zero_lsb +: 8];
			latency_value_one <= dynamic_reg[latency_one_lsb +: 8];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tolerance_present <= 1'b0;
			substates_present <= 1'b0;
			power_on_time_us <= 12'h000;
			power_on_scale_reserved <= 1'b0;
			default_common_mode_settle_us <= 8'h00;
			own_common_mode_settle_us <= 8'h00;
			substate_adv <= 5'h00;
		end else begin
			tolerance_present <= tolerance_reg[enable_bit];
			substates_present <= link_sleep_reg[enable_bit];
			case (link_sleep_reg[power_on_scale_lsb +: 2])
				2'h0: power_on_time_us <= 12'(link_sleep_reg[power_on_value_lsb +: 5]) * 12'(on_2_us);
				2'h1: power_on_time_us <= 12'(link_sleep_reg[power_on_value_lsb +: 5]) * 12'(on_10_us);
				2'h2: power_on_time_us <= 12'(link_sleep_reg[power_on_value_lsb +: 5]) * 12'(on_100_us);
				default: power_on_time_us <= 12'h000;
			endcase
			power_on_scale_reserved <= link_sleep_reg[power_on_scale_lsb +: 2] == 2'h3;
			default_common_mode_settle_us <= link_sleep_reg[default_settle_lsb +: 8];
			own_common_mode_settle_us <= link_sleep_reg[own_settle_lsb +: 8];
			substate_adv <= link_sleep_reg[low_power_adv_bit +: 5];
		end
	end

	// checks with a presetn antecedent start a cycle out of reset; a_bar_addr, a_msi_reserved check at once, a_write_ready one cycle after its antecedent
	a_msi_hide: assert property (@(posedge pclk) disable iff (!presetn)
		presetn |=> msi_present == !$past(msg_interrupt_reg[hide_bit]))
		else $error("msi presence wrong");
	a_msi_count: assert property (@(posedge pclk) disable iff (!presetn)
		presetn && msg_interrupt_reg[6:4] == 3'h5 |=> msi_vector_count == 6'h20)
		else $error("msi count wrong");
	a_msix_count: assert property (@(posedge pclk) disable iff (!presetn)
		presetn |=> msix_vector_count == {1'b0, $past(ext_msg_reg[26:16])} + 12'h001)
		else $error("msix count wrong");
	a_table_offset: assert property (@(posedge pclk) disable iff (!presetn)
		presetn |=> msix_table_byte_offset[2:0] == 3'b000
			&& msix_table_byte_offset[31:3] == $past(table_location_reg[31:3]))
		else $error("table offset wrong");
	a_bar_addr: assert property (@(posedge pclk) disable iff (!presetn)
		msix_table_bar_valid |-> msix_table_bar_addr >= 8'h10 && msix_table_bar_addr <= 8'h24)
		else $error("bar address out of range");
	a_write_ready: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && !pready) |=> pready)
		else $error("slave did not answer");
	a_msi_reserved: assert property (@(posedge pclk) disable iff (!presetn)
		msg_interrupt_reg[31:7] == 25'h0 && msg_interrupt_reg[3:2] == 2'b00)
		else $error("reserved bit set");
	a_substate_count: assert property (@(posedge pclk) disable iff (!presetn)
		presetn |=> substate_count == {1'b0, $past(dynamic_reg[7:3])} + 6'h01)
		else $error("substate count wrong");
	a_serial_show: assert property (@(posedge pclk) disable iff (!presetn)
		presetn |=> serial_present == $past(serial_config_reg[0]))
		else $error("serial presence wrong");
	c_write_hit: cover property (@(posedge pclk) disable iff (!presetn) wr_en && mapped);
	c_read_hit: cover property (@(posedge pclk) disable iff (!presetn) pready && !pwrite && !pslverr);
	c_unmapped: cover property (@(posedge pclk) disable iff (!presetn) pready && pslverr);
	c_msi_hidden: cover property (@(posedge pclk) disable iff (!presetn) !msi_present ##1 msi_present);
endmodule : pcie_capability_config_bank
`default_nettype wire

/* File: test/cfg_space_host.sv */
// host model that counts the capabilities present in configuration space
`timescale 1ns/1ps
`default_nettype none
module cfg_space_host (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [8:0] present,
	output var  logic [3:0] visible
);
	// one list entry for each capability that is present
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			visible <= 4'h0;
		end else begin
			visible <= 4'($countones(present));
		end
	end
endmodule : cfg_space_host
`default_nettype wire

/* File: test/pcie_capability_config_bank_test.sv */
// self-checking bench for the capability configuration bank
`timescale 1ns/1ps
`default_nettype none
module pcie_capability_config_bank_test;
	import cap_bank_pkg::*;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, rd, seed = 32'h0000e633, s [22];
	logic [3:0]  pstrb = 4'h0, visible, skip_gen_speeds, skip_rx_speeds;
	logic [31:0] prdata, msix_table_byte_offset, msix_pending_byte_offset, latency_select;
	logic        pready, pslverr, msi_present, msi_vector_mask_adv, msix_present, msix_table_bar_valid;
	logic        msix_pending_bar_valid, vendor_present, skip_present, serial_present, budget_present;
	logic        budget_system_allocated, dynamic_present, latency_unit_reserved, tolerance_present;
	logic        substates_present, power_on_scale_reserved;
	logic [5:0]  msi_vector_count, substate_count;
	logic [11:0] msix_vector_count, power_on_time_us;
	logic [7:0]  msix_table_bar_addr, msix_pending_bar_addr, latency_value_zero, latency_value_one;
	logic [7:0]  default_common_mode_settle_us, own_common_mode_settle_us;
	logic [15:0] vendor_cap_id;
	logic [63:0] serial_number;
	logic [6:0]  latency_unit_ms;
	logic [10:0] alloc_scale_hundredths;
	logic [255:0] share_array;
	logic [4:0]  substate_adv;
	int          mismatches = 0, compares = 0;
	localparam logic [11:0] addrs [22] = '{12'h0e8, 12'h0f0, 12'h0f4, 12'h0f8, 12'h110, 12'h120, 12'h130,
		12'h134, 12'h138, 12'h150, 12'h158, 12'h15c, 12'h160, 12'h164, 12'h168, 12'h16c, 12'h170, 12'h174,
		12'h178, 12'h17c, 12'h180, 12'h188};
	pcie_capability_config_bank u_pcie_capability_config_bank (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .msi_present, .msi_vector_count,
		.msi_vector_mask_adv, .msix_present, .msix_vector_count, .msix_table_byte_offset, .msix_table_bar_addr,
		.msix_table_bar_valid, .msix_pending_byte_offset, .msix_pending_bar_addr, .msix_pending_bar_valid,
		.vendor_present, .vendor_cap_id, .skip_present, .skip_gen_speeds, .skip_rx_speeds, .serial_present,
		.serial_number, .budget_present, .budget_system_allocated, .dynamic_present, .substate_count,
		.latency_unit_ms, .latency_unit_reserved, .alloc_scale_hundredths, .latency_select, .latency_value_zero,
		.latency_value_one, .share_array, .tolerance_present, .substates_present, .power_on_time_us,
		.power_on_scale_reserved, .default_common_mode_settle_us, .own_common_mode_settle_us, .substate_adv);
	cfg_space_host u_cfg_space_host (.pclk, .presetn, .visible, .present({msi_present, msix_present,
		vendor_present, skip_present, serial_present, budget_present, dynamic_present, tolerance_present,
		substates_present}));
	always #50 pclk = ~pclk;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic logic [31:0] wmask(input logic [11:0] a);
		case (a)
			12'h0e8: return 32'h0000_0073;
			12'h0f0: return 32'h07ff_0001;
			12'h110: return 32'hffff_0001;
			12'h120: return 32'h0000_ff01;
			12'h130, 12'h180: return 32'h0000_0001;
			12'h150: return 32'h0000_0003;
			12'h158: return 32'hffff_33f9;
			12'h188: return 32'hffff_fbf9;
			default: return 32'hffff_ffff;
		endcase
	endfunction : wmask
	function automatic logic [31:0] rstv(input logic [11:0] a);
		case (a)
			12'h0e8: return 32'h0000_0052;
			12'h0f0: return 32'h001f_0000;
			12'h0f4: return {29'h0c00, 3'h0};
			12'h0f8: return {29'h0e00, 3'h0};
			12'h110: return 32'h0001_0001;
			12'h188: return 32'h0000_00f8;
			default: return 32'h0;
		endcase
	endfunction : rstv
	function automatic logic [7:0] bar(input logic [2:0] c);
		return c < 6 ? 8'h10 + {3'h0, c, 2'h0} : 8'h00;
	endfunction : bar
	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] st);
		int n;
		n = 0;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, st};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		if (n >= 40) chk(1'b0, 1'b1, "no pready");
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic verify_all();
		for (int i = 0; i < 22; i++) begin
			apb(1'b0, addrs[i], 32'h0, 4'h0);
			chk(rd, s[i], "readback");
		end
		repeat (3) @(posedge pclk);
		chk(msi_present, !s[0][0], "msi on");
		chk(msi_vector_count, s[0][6:4] < 6 ? 64'h1 << s[0][6:4] : 64'h0, "msi cnt");
		chk(msi_vector_mask_adv, s[0][1], "vmask");
		chk(msix_present, !s[1][0], "msix on");
		chk(msix_vector_count, s[1][26:16] + 12'h1, "msix cnt");
		chk(msix_table_byte_offset, {s[2][31:3], 3'h0}, "tbl off");
		chk({msix_table_bar_valid, msix_table_bar_addr}, {s[2][2:0] < 6, bar(s[2][2:0])}, "tbl bar");
		chk(msix_pending_byte_offset, {s[3][31:3], 3'h0}, "pba off");
		chk({msix_pending_bar_valid, msix_pending_bar_addr}, {s[3][2:0] < 6, bar(s[3][2:0])}, "pba bar");
		chk({vendor_present, vendor_cap_id}, {s[4][0], s[4][31:16]}, "vendor");
		chk({skip_present, skip_gen_speeds, skip_rx_speeds}, {s[5][0], s[5][15:8]}, "skip");
		chk(serial_present, s[6][0], "serial on");
		chk(serial_number, {s[8], s[7]}, "serial");
		chk({budget_present, budget_system_allocated}, {s[9][0], s[9][1]}, "budget");
		chk({dynamic_present, substate_count}, {s[10][0], s[10][7:3] + 6'h1}, "dyn");
		chk({latency_value_one, latency_value_zero, latency_select}, {s[10][31:16], s[11]}, "lat");
		chk({latency_unit_reserved, latency_unit_ms}, s[10][9:8] == 0 ? 1 : s[10][9:8] == 1 ? 10 :
			s[10][9:8] == 2 ? 100 : 128, "unit");
		chk(alloc_scale_hundredths, s[10][13:12] == 0 ? 1000 : s[10][13:12] == 1 ? 100 :
			s[10][13:12] == 2 ? 10 : 1, "scale");
		for (int w = 0; w < 8; w++) chk(share_array[32*w +: 32], s[12+w], "share");
		chk({tolerance_present, substates_present}, {s[20][0], s[21][0]}, "ltr l1");
		chk({power_on_scale_reserved, power_on_time_us}, s[21][9:8] == 3 ? 13'h1000 : s[21][15:11] *
			(s[21][9:8] == 0 ? 2 : s[21][9:8] == 1 ? 10 : 100), "pwr on");
		chk({default_common_mode_settle_us, own_common_mode_settle_us}, s[21][31:16], "settle");
		chk(substate_adv, s[21][7:3], "adv");
		chk(visible, 4'h0 + !s[0][0] + !s[1][0] + s[4][0] + s[5][0] + s[6][0] + s[9][0] + s[10][0] + s[20][0]
			+ s[21][0], "host");
	endtask : verify_all
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (20000) @(posedge pclk);
		mismatches++;
		print_verdict();
	end
	initial begin
		logic [31:0] d, lm;
		logic [3:0]  st;
		for (int i = 0; i < 22; i++) s[i] = rstv(addrs[i]);
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		verify_all();
		$display("test reset values done");
		for (int r = 0; r < 13; r++) begin
			for (int i = 0; i < 22; i++) begin
				d = r < 8 ? {8{r[3:0]}} : r == 12 ? 32'hffff_ffff : rnd();
				st = r < 9 ? 4'hf : 4'(rnd());
				if (i == 21 && d[3]) d[7] = 1'b1;
				apb(1'b1, addrs[i], d, st);
				chk(er, 1'b0, "wr err");
				lm = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}} & wmask(addrs[i]);
				s[i] = (s[i] & ~lm) | (d & lm);
			end
			verify_all();
		end
		$display("test codes and random data done");
		apb(1'b0, 12'h0ec, 32'h0, 4'h0);
		chk({er, rd}, {1'b1, 32'h0}, "unmapped");
		apb(1'b1, 12'h0e9, 32'h0, 4'hf);
		chk(er, 1'b1, "misalign");
		verify_all();
		$display("test refused access done");
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 22; i++) s[i] = rstv(addrs[i]);
		verify_all();
		$display("test second reset done");
		print_verdict();
	end
endmodule : pcie_capability_config_bank_test
`default_nettype wire
